/* hw/hbra_pkg.sv */
package hbra_pkg;
// Operation
// - Priority access asserts synchronously; its release may be asynchronous.
// - Ready output supports open-drain and active-drive styles.
// - Select and request both low drive ready low until handover.
// - After grant, ready is released: floated or driven high per style.
// - Active-drive ready stops driving when select or request goes high; the code keeps it driven through S_RD and S_WR, and one cycle more from S_HAND.
// - A read pulls ready low until the requested data are available.
// - Read data are valid on the bus before ready is released.
// - A write pulls ready low until the write can be accepted.
// - Ready is released only on a clock edge.
// - Grant changes only on a clock edge.
// - Mastership passes among processors or to the host via request and grant.

    // ----------------------------------------------------------------
    // Sizes and timing
    // ----------------------------------------------------------------
    localparam int ADDR_W       = 32;
    localparam int DATA_W       = 48;
    localparam int CLK_PERIOD_NS = 100;
    localparam int READ_LOW_NS  = 45;
    localparam int WRITE_LOW_NS = 15;
    localparam int READ_LOW_CYC  = (READ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_LOW_CYC = (WRITE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HANDOVER_CYC = 2;
    localparam logic [ADDR_W-1:0] RESET_ADDR = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RESET_DATA = 48'h0000_0000_0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {HBRA_OPEN_DRAIN, HBRA_ACTIVE_DRIVE} hbra_style_e;

    typedef struct packed {
        logic              sel_n;
        logic              rd_n;
        logic              wr_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hbra_host_s;

    typedef struct packed {
        logic              req;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hbra_mem_req_s;
endpackage

/* hw/hbra_hold_cnt.sv */
module hbra_hold_cnt
    import hbra_pkg::*;
#(
    parameter int W = 4
)(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    // Status
    output logic              zero
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (load)
            cnt_nxt = value;
        else if (cnt_r != '0)
            cnt_nxt = cnt_r - 1'b1;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    assign zero = (cnt_r == '0);
endmodule // hbra_hold_cnt

/* hw/hbra_host_port.sv */
module hbra_host_port
    import hbra_pkg::*;
#(
    parameter int          CNT_W    = 4,
    parameter hbra_style_e STYLE    = HBRA_OPEN_DRAIN
)(
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rstn,
    // Host bus arbitration
    input  wire logic                    host_bus_request_n,
    output logic                         host_bus_grant_n,
    input  wire logic                    bus_idle,
    // Host strobes
    input  wire hbra_pkg::hbra_host_s    host,
    // Ready pin, two signals
    output logic                         host_wait_ready_o,
    output logic                         host_wait_ready_oe,
    // Data pins
    output logic [hbra_pkg::DATA_W-1:0]  host_data_o,
    output logic                         host_data_oe,
    // Internal memory and I/O register port
    output hbra_pkg::hbra_mem_req_s      mem_req,
    input  wire logic                    mem_done,
    input  wire logic [hbra_pkg::DATA_W-1:0] mem_rdata
);
    import hbra_pkg::*;

    // ----------------------------------------------------------------
    // Access state machine
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {S_IDLE, S_HAND, S_GRANT, S_RD, S_WR, S_DONE} hbra_state_e;

    hbra_state_e             st_r,   st_nxt;
    logic                    grant_r, grant_nxt;
    logic                    rdy_o_r, rdy_o_nxt;
    logic                    rdy_oe_r, rdy_oe_nxt;
    logic [DATA_W-1:0]       dat_r,  dat_nxt;
    logic                    doe_r,  doe_nxt;
    hbra_mem_req_s           mreq_r, mreq_nxt;
    logic                    cnt_load;
    logic [CNT_W-1:0]        cnt_val;
    logic                    cnt_zero;
    logic                    asked;

    // Request is a plain synchronous input; a late one is caught next edge.
    assign asked = !host.sel_n && !host_bus_request_n;

    hbra_hold_cnt #(.W(CNT_W)) u_hold (
        .core_clk (core_clk),
        .rstn     (rstn),
        .load     (cnt_load),
        .value    (cnt_val),
        .zero     (cnt_zero)
    );

    always_comb
    begin
        st_nxt     = st_r;
        grant_nxt  = grant_r;
        rdy_o_nxt  = 1'b0;
        rdy_oe_nxt = 1'b0;
        dat_nxt    = dat_r;
        doe_nxt    = doe_r;
        mreq_nxt   = mreq_r;
        mreq_nxt.req = 1'b0;
        cnt_load   = 1'b0;
        cnt_val    = '0;
        unique case (st_r)
            S_IDLE:
            begin
                grant_nxt = 1'b0;
                doe_nxt   = 1'b0;
                if (asked)
                begin
                    st_nxt     = S_HAND;
                    rdy_oe_nxt = 1'b1;
                    cnt_load   = 1'b1;
                    cnt_val    = CNT_W'(HANDOVER_CYC);
                end
            end
            S_HAND:
            begin
                rdy_oe_nxt = 1'b1;
                if (!asked)
                    st_nxt = S_IDLE;
                else if (cnt_zero && bus_idle)
                begin
                    // Grant and ready release both land on this edge.
                    grant_nxt = 1'b1;
                    st_nxt    = S_GRANT;
                    rdy_o_nxt  = 1'b1;
                    rdy_oe_nxt = (STYLE == HBRA_ACTIVE_DRIVE);
                end
            end
            S_GRANT:
            begin
                doe_nxt = 1'b0;
                if (host_bus_request_n)
                begin
                    grant_nxt = 1'b0;
                    st_nxt    = S_IDLE;
                end
                else if (!host.sel_n && !host.rd_n)
                begin
                    st_nxt        = S_RD;
                    rdy_oe_nxt    = 1'b1;
                    mreq_nxt.req  = 1'b1;
                    mreq_nxt.wr   = 1'b0;
                    mreq_nxt.addr = host.addr;
                    cnt_load      = 1'b1;
                    cnt_val       = CNT_W'(READ_LOW_CYC);
                end
                else if (!host.sel_n && !host.wr_n)
                begin
                    st_nxt         = S_WR;
                    rdy_oe_nxt     = 1'b1;
                    mreq_nxt.req   = 1'b1;
                    mreq_nxt.wr    = 1'b1;
                    mreq_nxt.addr  = host.addr;
                    mreq_nxt.wdata = host.wdata;
                    cnt_load       = 1'b1;
                    cnt_val        = CNT_W'(WRITE_LOW_CYC);
                end
                else
                begin
                    rdy_o_nxt  = 1'b1;
                    rdy_oe_nxt = (STYLE == HBRA_ACTIVE_DRIVE) && asked;
                end
            end
            S_RD, S_WR:
            begin
                rdy_oe_nxt = 1'b1;
                if (mem_done && st_r == S_RD)
                begin
                    dat_nxt = mem_rdata;
                    doe_nxt = 1'b1;
                end
                if ((mem_done || (st_r == S_RD && doe_r)) && cnt_zero)
                begin
                    // Data were loaded at least one edge earlier than release.
                    if (st_r == S_WR || doe_r)
                    begin
                        st_nxt     = S_DONE;
                        rdy_o_nxt  = 1'b1;
                        rdy_oe_nxt = (STYLE == HBRA_ACTIVE_DRIVE);
                    end
                end
            end
            S_DONE:
            begin
                // Host keeps its strobe low until here.
                rdy_o_nxt  = 1'b1;
                rdy_oe_nxt = (STYLE == HBRA_ACTIVE_DRIVE) && asked;
                if (host.rd_n && host.wr_n)
                begin
                    st_nxt  = S_GRANT;
                    doe_nxt = 1'b0;
                end
            end
            default:
                st_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r     <= S_IDLE;
            grant_r  <= 1'b0;
            rdy_o_r  <= 1'b0;
            rdy_oe_r <= 1'b0;
            dat_r    <= RESET_DATA;
            doe_r    <= 1'b0;
            mreq_r   <= '0;
        end
        else
        begin
            st_r     <= st_nxt;
            grant_r  <= grant_nxt;
            rdy_o_r  <= rdy_o_nxt;
            rdy_oe_r <= rdy_oe_nxt;
            dat_r    <= dat_nxt;
            doe_r    <= doe_nxt;
            mreq_r   <= mreq_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // The host side of the address and first-access rules lives outside.
    assign host_bus_grant_n   = !grant_r;
    assign host_wait_ready_o  = rdy_o_r;
    assign host_wait_ready_oe = rdy_oe_r;
    assign host_data_o        = dat_r;
    assign host_data_oe       = doe_r;
    assign mem_req            = mreq_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_read_start;
        st_r == S_GRANT && !host_bus_request_n && !host.sel_n && !host.rd_n;
    endsequence

    a_grant_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        $changed(host_bus_grant_n) |-> $past(st_r) == S_HAND || $past(st_r) == S_GRANT || $past(st_r) == S_IDLE)
        else $error("grant changed from an unexpected state");
    a_wait_low: assert property (@(posedge core_clk) disable iff (!rstn)
        st_r == S_IDLE && asked |=> host_wait_ready_oe && !host_wait_ready_o)
        else $error("ready not pulled low on request");
    a_release_grant: assert property (@(posedge core_clk) disable iff (!rstn)
        $fell(host_bus_grant_n) |-> host_wait_ready_o)
        else $error("ready not released with grant");
    a_od_float: assert property (@(posedge core_clk) disable iff (!rstn)
        STYLE == HBRA_OPEN_DRAIN && host_wait_ready_o |-> !host_wait_ready_oe)
        else $error("open-drain ready driven high");
    a_ad_stop: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_r == S_GRANT || st_r == S_DONE) && !asked |=> !host_wait_ready_oe)
        else $error("active ready still driven after deselect");
    a_read_wait: assert property (@(posedge core_clk) disable iff (!rstn)
        s_read_start |=> host_wait_ready_oe && !host_wait_ready_o)
        else $error("read did not pull ready low");
    a_data_first: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(st_r == S_DONE) && $past(st_r) == S_RD |-> $past(host_data_oe))
        else $error("ready released before read data valid");
    a_write_wait: assert property (@(posedge core_clk) disable iff (!rstn)
        st_r == S_WR |-> host_wait_ready_oe && !host_wait_ready_o)
        else $error("write wait not held low");
endmodule // hbra_host_port

/* sim/hbra_host_model.sv */
module hbra_host_model
    import hbra_pkg::*;
(
    // Clock
    input  wire logic                          core_clk,
    // Bus handover
    input  wire logic                          host_bus_grant_n,
    output logic                               host_bus_request_n,
    // Strobes and pins
    output hbra_pkg::hbra_host_s               host,
    input  wire logic                          ready_pin,
    input  wire logic [hbra_pkg::DATA_W-1:0]   host_data_o,
    input  wire logic                          host_data_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        host_bus_request_n = 1'b1;
        host = '{sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: '0, wdata: '0};
    end

    // The upper address line is pushed high so the first access misses shared space.
    task automatic request();
        @(posedge core_clk);
        host.sel_n         <= 1'b0;
        host_bus_request_n <= 1'b0;
        host.addr          <= {1'b1, host.addr[ADDR_W-2:0]};
    endtask

    task automatic wait_grant(output bit ok);
        ok = 1'b0;
        for (int n = 0; n < 40 && !ok; n++)
        begin
            @(negedge core_clk);
            ok = !host_bus_grant_n;
        end
    endtask

    // The strobe stays low until ready has gone low and come back high.
    task automatic access(input bit wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                          output logic [DATA_W-1:0] q, output logic qoe, output bit ok);
        bit low;
        repeat (2) @(posedge core_clk);
        host.addr  <= a;
        host.wdata <= d;
        if (wr)
            host.wr_n <= 1'b0;
        else
            host.rd_n <= 1'b0;
        ok  = 1'b0;
        low = 1'b0;
        for (int n = 0; n < 40 && !ok; n++)
        begin
            @(negedge core_clk);
            if (!ready_pin)
                low = 1'b1;
            else if (low)
                ok = 1'b1;
        end
        q   = host_data_o;
        qoe = host_data_oe;
        @(posedge core_clk);
        host.rd_n  <= 1'b1;
        host.wr_n  <= 1'b1;
        host.wdata <= ~d;
    endtask

    task automatic drop();
        @(posedge core_clk);
        host.sel_n         <= 1'b1;
        host_bus_request_n <= 1'b1;
    endtask
endmodule // hbra_host_model

/* sim/testbench.sv */
module testbench
    import hbra_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                core_clk;
    logic                rstn;
    logic                host_bus_request_n;
    logic                host_bus_grant_n;
    logic                bus_idle;
    logic                mem_done = 1'b0;
    logic                rdy_o;
    logic                rdy_oe;
    logic                rdy_o_od;
    logic                rdy_oe_od;
    logic                data_oe;
    logic                pend = 1'b0;
    logic [DATA_W-1:0]   data_o;
    logic [DATA_W-1:0]   mem_rdata = '0;
    hbra_host_s          host;
    hbra_mem_req_s       mem_req;
    hbra_mem_req_s       last_req;
    int                  dly;
    int                  error_cnt = 0;
    int                  cmp_count = 0;
    wire logic           ready_pin = rdy_oe ? rdy_o : 1'b1;

    hbra_host_port #(.CNT_W(4), .STYLE(HBRA_ACTIVE_DRIVE)) uut (
        .core_clk(core_clk), .rstn(rstn), .host_bus_request_n(host_bus_request_n),
        .host_bus_grant_n(host_bus_grant_n), .bus_idle(bus_idle), .host(host),
        .host_wait_ready_o(rdy_o), .host_wait_ready_oe(rdy_oe), .host_data_o(data_o),
        .host_data_oe(data_oe), .mem_req(mem_req), .mem_done(mem_done), .mem_rdata(mem_rdata));

    // Open-drain twin sees the same inputs, so only its ready pin is watched.
    hbra_host_port #(.CNT_W(4), .STYLE(HBRA_OPEN_DRAIN)) uut_od (
        .core_clk(core_clk), .rstn(rstn), .host_bus_request_n(host_bus_request_n),
        .host_bus_grant_n(), .bus_idle(bus_idle), .host(host),
        .host_wait_ready_o(rdy_o_od), .host_wait_ready_oe(rdy_oe_od), .host_data_o(),
        .host_data_oe(), .mem_req(), .mem_done(mem_done), .mem_rdata(mem_rdata));

    hbra_host_model host_m (
        .core_clk(core_clk), .host_bus_grant_n(host_bus_grant_n), .host_bus_request_n(host_bus_request_n),
        .host(host), .ready_pin(ready_pin), .host_data_o(data_o), .host_data_oe(data_oe));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    function automatic logic [DATA_W-1:0] exp_data(input logic [ADDR_W-1:0] a);
        return {a[15:0], ~a};
    endfunction

    // Memory side answers after a random stall so ready must track completion.
    always @(posedge core_clk)
    begin
        mem_done  <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req.req === 1'b1)
        begin
            pend     <= 1'b1;
            dly      <= $urandom_range(3);
            last_req <= mem_req;
        end
        else if (pend && dly == 0)
        begin
            pend      <= 1'b0;
            mem_done  <= 1'b1;
            mem_rdata <= exp_data(last_req.addr);
        end
        else if (pend)
            dly <= dly - 1;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("errors=%0d compares=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] q;
        logic              qoe;
        bit                ok;
        bit                wr;
        rstn      = 1'b0;
        bus_idle  = 1'b0;
        void'($urandom(32'hEACE));
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        for (int r = 0; r < 2; r++)
        begin
            @(posedge core_clk);
            bus_idle <= r[0];
            host_m.request();
            repeat (6) @(posedge core_clk);
            @(negedge core_clk);
            check(ready_pin, r[0]);
            check(host_bus_grant_n, !r[0]);
            check(rdy_oe_od, !r[0]);
            check(rdy_o_od, r[0]);
            @(posedge core_clk);
            bus_idle <= 1'b1;
            host_m.wait_grant(ok);
            if (!ok)
            begin
                error_cnt++;
                close_out();
            end
            check(ready_pin, 1'b1);
            check(rdy_oe_od, 1'b0);
            for (int i = 0; i < 4; i++)
            begin
                wr = $urandom_range(1);
                a  = (i == 3) ? '1 : $urandom;
                a[ADDR_W-1] = 1'b1;
                d  = {16'($urandom), $urandom};
                host_m.access(wr, a, d, q, qoe, ok);
                if (!ok)
                begin
                    error_cnt++;
                    close_out();
                end
                check(pend, 1'b0);
                if (wr)
                begin
                    check(last_req.wr, 1'b1);
                    check(last_req.addr, a);
                    check(last_req.wdata, d);
                end
                else
                begin
                    check(last_req.wr, 1'b0);
                    check(last_req.addr, a);
                    check(qoe, 1'b1);
                    check(q, exp_data(a));
                end
            end
            host_m.drop();
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            check(rdy_oe, 1'b0);
            check(host_bus_grant_n, 1'b1);
        end
        close_out();
    end
endmodule // testbench
